// [hdl/cctu_map.svh]
`ifndef CCTU_MAP_SVH
`define CCTU_MAP_SVH

`define CCTU_ADDR_W        3
`define CCTU_ADR_CONTROL   3'h0
`define CCTU_ADR_CMP_LOW   3'h1
`define CCTU_ADR_CMP_HIGH  3'h2
`define CCTU_ADR_IRQ_EN    3'h3
`define CCTU_ADR_IRQ_FLAGS 3'h4
`define CCTU_ADR_TMR_LOW   3'h5
`define CCTU_ADR_TMR_HIGH  3'h6
`define CCTU_ADR_TMR_CTRL  3'h7

`define CCTU_MODE_LSB      0
`define CCTU_MODE_MSB      3
`define CCTU_DUTY_LSB      4
`define CCTU_DUTY_MSB      5
`define CCTU_FLAG_BIT      0
`define CCTU_TCTL_ON_BIT   0
`define CCTU_TCTL_EXT_BIT  1
`define CCTU_TCTL_OVF_BIT  7

`define CCTU_MODE_OFF      4'h0
`define CCTU_MODE_TOGGLE   4'h2
`define CCTU_MODE_CAP_FALL 4'h4
`define CCTU_MODE_CAP_RISE 4'h5
`define CCTU_MODE_CAP_4TH  4'h6
`define CCTU_MODE_CAP_16TH 4'h7
`define CCTU_MODE_SET      4'h8
`define CCTU_MODE_CLEAR    4'h9
`define CCTU_MODE_SWI      4'ha
`define CCTU_MODE_SPECIAL  4'hb

`define CCTU_PRE_4TH_LAST  4'h3
`define CCTU_PRE_16TH_LAST 4'hf
`define CCTU_INSTR_DIV_LAST 2'h3

`define CCTU_RST_BYTE      8'h00
`define CCTU_RST_WORD      16'h0000

`endif

// [hdl/cctu_pkg.sv]
package cctu_pkg;

	typedef logic [7:0]  cctu_byte_t;
	typedef logic [15:0] cctu_word_t;
	typedef logic [2:0]  cctu_addr_t;

	typedef enum logic [2:0] {
		CCTU_ACT_OFF,
		CCTU_ACT_CAPTURE,
		CCTU_ACT_TOGGLE,
		CCTU_ACT_SET,
		CCTU_ACT_CLEAR,
		CCTU_ACT_SWI,
		CCTU_ACT_SPECIAL
	} cctu_act_t;

endpackage

// [hdl/cctu_unit.sv]
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "cctu_map.svh"

module cctu_unit (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire cctu_pkg::cctu_addr_t addr,
	input  wire cctu_pkg::cctu_byte_t wdata,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output cctu_pkg::cctu_byte_t    rdata,
	input  wire logic               unit_pin_in,
	output logic                    unit_pin_out,
	output logic                    unit_pin_oe,
	input  wire logic               timer_ext_clock_input,
	input  wire logic               sleep_active,
	input  wire logic               adc_enabled,
	output logic                    adc_start,
	output logic                    special_event_trigger,
	output logic                    unit_interrupt_flag,
	output logic                    timer_overflow_flag,
	output logic                    wake_request
);
	import cctu_pkg::*;

	// Mode decode, shared by prescaler, compare and pin logic
	function automatic cctu_act_t decode_mode(input logic [3:0] m);
		case (m)
			`CCTU_MODE_CAP_FALL,
			`CCTU_MODE_CAP_RISE,
			`CCTU_MODE_CAP_4TH,
			`CCTU_MODE_CAP_16TH: decode_mode = CCTU_ACT_CAPTURE;
			`CCTU_MODE_TOGGLE:   decode_mode = CCTU_ACT_TOGGLE;
			`CCTU_MODE_SET:      decode_mode = CCTU_ACT_SET;
			`CCTU_MODE_CLEAR:    decode_mode = CCTU_ACT_CLEAR;
			`CCTU_MODE_SWI:      decode_mode = CCTU_ACT_SWI;
			`CCTU_MODE_SPECIAL:  decode_mode = CCTU_ACT_SPECIAL;
			default:             decode_mode = CCTU_ACT_OFF;
		endcase
	endfunction

	cctu_byte_t unit_control_reg;
	cctu_word_t compare_value_reg;
	cctu_byte_t irq_enable_reg;
	logic       unit_flag_reg;
	cctu_word_t timer_count_reg;
	logic       timer_on_reg;
	logic       timer_ext_sel_reg;
	logic       timer_ovf_reg;
	cctu_byte_t rdata_reg;
	logic [3:0] prescale_reg;
	logic [1:0] instr_div_reg;
	logic       compare_latch_reg;
	logic       match_prev_reg;
	logic       reset_pending_reg;
	logic       trigger_reg;
	logic       adc_start_reg;
	logic       wake_reg;
	logic       pin_oe_reg;
	logic       pin_sync1_reg;
	logic       pin_sync2_reg;
	logic       pin_last_reg;
	logic       ext_sync1_reg;
	logic       ext_sync2_reg;
	logic       ext_last_reg;

	logic [3:0] mode;
	cctu_act_t  act;
	logic       wr_ctrl;
	logic       wr_flags;
	logic       pin_rise;
	logic       pin_fall;
	logic       ext_rise;
	logic       instr_tick;
	logic       timer_tick;
	logic       match_now;
	logic       match_event;
	logic       capture_event;
	logic       timer_clear;
	logic       timer_wrap;

	assign mode     = unit_control_reg[`CCTU_MODE_MSB:`CCTU_MODE_LSB];
	assign act      = decode_mode(mode);
	assign wr_ctrl  = wr_stb && (addr == `CCTU_ADR_CONTROL);
	assign wr_flags = wr_stb && (addr == `CCTU_ADR_IRQ_FLAGS);

	// Pin and external clock synchronisers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_sync1_reg <= 1'b0;
			pin_sync2_reg <= 1'b0;
			pin_last_reg  <= 1'b0;
		end else begin
			pin_sync1_reg <= unit_pin_in;
			pin_sync2_reg <= pin_sync1_reg;
			pin_last_reg  <= pin_sync2_reg;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_sync1_reg <= 1'b0;
			ext_sync2_reg <= 1'b0;
			ext_last_reg  <= 1'b0;
		end else begin
			ext_sync1_reg <= timer_ext_clock_input;
			ext_sync2_reg <= ext_sync1_reg;
			ext_last_reg  <= ext_sync2_reg;
		end
	end

	assign pin_rise = pin_sync2_reg && !pin_last_reg;
	assign pin_fall = !pin_sync2_reg && pin_last_reg;
	assign ext_rise = ext_sync2_reg && !ext_last_reg;

	// Instruction-rate tick; this source is halted while asleep
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			instr_div_reg <= 2'h0;
		end else if (!sleep_active) begin
			instr_div_reg <= instr_div_reg + 2'h1;
		end
	end

	assign instr_tick = !sleep_active && (instr_div_reg == `CCTU_INSTR_DIV_LAST);
	// External source keeps ticking through sleep
	assign timer_tick = timer_on_reg && (timer_ext_sel_reg ? ext_rise : instr_tick);

	// Compare and special event
	assign match_now   = (timer_count_reg == compare_value_reg);
	// First cycle of equality only, so a held match acts once
	assign match_event = match_now && !match_prev_reg;
	assign timer_clear = reset_pending_reg && timer_tick && match_now;
	// A special event clear is not a wrap and leaves the overflow flag alone
	assign timer_wrap  = timer_tick && !timer_clear && (timer_count_reg == 16'hffff);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			match_prev_reg <= 1'b0;
		end else begin
			match_prev_reg <= match_now;
		end
	end

	// Prescaler counter and capture event
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prescale_reg <= 4'h0;
		end else if (act != CCTU_ACT_CAPTURE) begin
			prescale_reg <= 4'h0;
		end else if (pin_rise) begin
			// Not cleared on a capture-to-capture change, so a stale
			// count can fire early
			prescale_reg <= prescale_reg + 4'h1;
		end
	end

	always_comb begin
		capture_event = 1'b0;
		if (act == CCTU_ACT_CAPTURE) begin
			case (mode)
				`CCTU_MODE_CAP_FALL:  capture_event = pin_fall;
				`CCTU_MODE_CAP_RISE:  capture_event = pin_rise;
				`CCTU_MODE_CAP_4TH:
					// Only the low two bits count here; the top bits may hold a stale count
					capture_event = pin_rise
						&& ({2'h0, prescale_reg[1:0]} == `CCTU_PRE_4TH_LAST);
				`CCTU_MODE_CAP_16TH:
					capture_event = pin_rise && (prescale_reg == `CCTU_PRE_16TH_LAST);
				default: capture_event = 1'b0;
			endcase
		end
	end

	// Control register; a write of zero switches the unit off
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			unit_control_reg <= `CCTU_RST_BYTE;
		end else if (wr_ctrl) begin
			unit_control_reg <= {2'h0, wdata[5:0]};
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_enable_reg <= `CCTU_RST_BYTE;
		end else if (wr_stb && addr == `CCTU_ADR_IRQ_EN) begin
			irq_enable_reg <= {7'h00, wdata[`CCTU_FLAG_BIT]};
		end
	end

	// Compare value pair; captures overwrite unread data
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			compare_value_reg <= `CCTU_RST_WORD;
		end else if (capture_event) begin
			compare_value_reg <= timer_count_reg;
		end else if (wr_stb && addr == `CCTU_ADR_CMP_LOW) begin
			compare_value_reg[7:0] <= wdata;
		end else if (wr_stb && addr == `CCTU_ADR_CMP_HIGH) begin
			compare_value_reg[15:8] <= wdata;
		end
	end

	// Unit flag: hardware set beats a software clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			unit_flag_reg <= 1'b0;
		end else if (capture_event) begin
			unit_flag_reg <= 1'b1;
		end else if (match_event && act != CCTU_ACT_CAPTURE && act != CCTU_ACT_OFF) begin
			unit_flag_reg <= 1'b1;
		end else if (wr_flags) begin
			unit_flag_reg <= wdata[`CCTU_FLAG_BIT];
		end
	end

	// Timer count
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timer_count_reg <= `CCTU_RST_WORD;
		end else if (wr_stb && addr == `CCTU_ADR_TMR_LOW) begin
			timer_count_reg[7:0] <= wdata;
		end else if (wr_stb && addr == `CCTU_ADR_TMR_HIGH) begin
			timer_count_reg[15:8] <= wdata;
		end else if (timer_clear) begin
			timer_count_reg <= `CCTU_RST_WORD;
		end else if (timer_tick) begin
			timer_count_reg <= timer_count_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timer_on_reg      <= 1'b0;
			timer_ext_sel_reg <= 1'b0;
		end else if (wr_stb && addr == `CCTU_ADR_TMR_CTRL) begin
			timer_on_reg      <= wdata[`CCTU_TCTL_ON_BIT];
			timer_ext_sel_reg <= wdata[`CCTU_TCTL_EXT_BIT];
		end
	end

	// Overflow flag set only by a real wrap or a software write of timer control bit 7
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timer_ovf_reg <= 1'b0;
		end else if (timer_wrap) begin
			timer_ovf_reg <= 1'b1;
		end else if (wr_stb && addr == `CCTU_ADR_TMR_CTRL) begin
			timer_ovf_reg <= wdata[`CCTU_TCTL_OVF_BIT];
		end
	end

	// Pending timer reset after a special event trigger
	// Dropped when the match goes away before the next timer tick
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reset_pending_reg <= 1'b0;
		end else if (act != CCTU_ACT_SPECIAL || !match_now) begin
			reset_pending_reg <= 1'b0;
		end else if (timer_tick) begin
			reset_pending_reg <= 1'b0;
		end else if (match_event) begin
			reset_pending_reg <= 1'b1;
		end
	end

	// One-cycle pulses, launched with the unit flag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			trigger_reg   <= 1'b0;
			adc_start_reg <= 1'b0;
		end else begin
			trigger_reg   <= (act == CCTU_ACT_SPECIAL) && match_event;
			adc_start_reg <= (act == CCTU_ACT_SPECIAL) && match_event && adc_enabled;
		end
	end

	// Compare output latch and pin ownership
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			compare_latch_reg <= 1'b0;
		end else if (wr_ctrl && wdata == 8'h00) begin
			compare_latch_reg <= 1'b0;
		end else if (match_event) begin
			case (act)
				CCTU_ACT_TOGGLE: compare_latch_reg <= !compare_latch_reg;
				CCTU_ACT_SET:    compare_latch_reg <= 1'b1;
				CCTU_ACT_CLEAR:  compare_latch_reg <= 1'b0;
				default:         compare_latch_reg <= compare_latch_reg;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_oe_reg <= 1'b0;
		end else begin
			// Pin released in capture, interrupt-only and trigger modes
			pin_oe_reg <= (act == CCTU_ACT_TOGGLE) || (act == CCTU_ACT_SET)
				|| (act == CCTU_ACT_CLEAR);
		end
	end

	// Capture while asleep asks for wake-up
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= capture_event && sleep_active;
		end
	end

	// Register read, data one cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_reg <= `CCTU_RST_BYTE;
		end else if (rd_stb) begin
			case (addr)
				`CCTU_ADR_CONTROL:   rdata_reg <= unit_control_reg;
				`CCTU_ADR_CMP_LOW:   rdata_reg <= compare_value_reg[7:0];
				`CCTU_ADR_CMP_HIGH:  rdata_reg <= compare_value_reg[15:8];
				`CCTU_ADR_IRQ_EN:    rdata_reg <= irq_enable_reg;
				`CCTU_ADR_IRQ_FLAGS: rdata_reg <= {7'h00, unit_flag_reg};
				`CCTU_ADR_TMR_LOW:   rdata_reg <= timer_count_reg[7:0];
				`CCTU_ADR_TMR_HIGH:  rdata_reg <= timer_count_reg[15:8];
				`CCTU_ADR_TMR_CTRL:
					rdata_reg <= {timer_ovf_reg, 5'h00, timer_ext_sel_reg, timer_on_reg};
				default:             rdata_reg <= `CCTU_RST_BYTE;
			endcase
		end else begin
			rdata_reg <= `CCTU_RST_BYTE;
		end
	end

	assign rdata                 = rdata_reg;
	assign unit_pin_out          = compare_latch_reg;
	assign unit_pin_oe           = pin_oe_reg;
	assign adc_start             = adc_start_reg;
	assign special_event_trigger = trigger_reg;
	assign unit_interrupt_flag   = unit_flag_reg;
	assign timer_overflow_flag   = timer_ovf_reg;
	assign wake_request          = wake_reg;

endmodule

// [tb/cctu_far_side.sv]
`timescale 1ns/10ps
module cctu_far_side (
	input  wire logic mclk,
	output logic      ext_clk,
	output logic      pin
);
	initial begin
		ext_clk = 1'b0;
		pin = 1'b0;
	end

	// Slow tick kept well under mclk, so the synced timer never misses one
	task automatic pulses(input logic on_pin, input int n);
		repeat (n) begin
			repeat (4) @(posedge mclk);
			if (on_pin) pin <= 1'b1;
			else ext_clk <= 1'b1;
			repeat (4) @(posedge mclk);
			if (on_pin) pin <= 1'b0;
			else ext_clk <= 1'b0;
		end
		repeat (6) @(posedge mclk);
	endtask
endmodule

// [tb/cctu_unit_assertions.sv]
`timescale 1ns/10ps
`include "cctu_map.svh"
module cctu_unit_chk (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire cctu_pkg::cctu_addr_t addr,
	input  wire cctu_pkg::cctu_byte_t wdata,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	input  wire cctu_pkg::cctu_byte_t rdata,
	input  wire logic                 unit_pin_out,
	input  wire logic                 unit_pin_oe,
	input  wire logic                 sleep_active,
	input  wire logic                 adc_start,
	input  wire logic                 special_event_trigger,
	input  wire logic                 unit_interrupt_flag,
	input  wire logic                 timer_overflow_flag,
	input  wire logic                 wake_request
);
	import cctu_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	chk_trig_pulse: assert property (special_event_trigger |=> !special_event_trigger)
		else $error("trigger pulse too long");
	chk_adc_gate: assert property (adc_start |-> special_event_trigger)
		else $error("adc start without trigger");
	chk_trig_flag: assert property (special_event_trigger |-> unit_interrupt_flag)
		else $error("trigger without unit flag");
	chk_trig_pin_free: assert property (special_event_trigger |-> !unit_pin_oe)
		else $error("pin driven in special mode");
	chk_no_ovf: assert property (special_event_trigger && !timer_overflow_flag
		|=> !timer_overflow_flag [*4]) else $error("overflow set by trigger reset");
	chk_zero_ctrl: assert property (wr_stb && addr == `CCTU_ADR_CONTROL && wdata == 8'h00
		|=> ##1 (!unit_pin_out && !unit_pin_oe)) else $error("latch not low after zero");
	chk_flag_sticky: assert property (unit_interrupt_flag
		&& !(wr_stb && addr == `CCTU_ADR_IRQ_FLAGS) |=> unit_interrupt_flag)
		else $error("flag dropped without software");
	chk_wake_sleep: assert property (wake_request |-> $past(sleep_active)
		&& unit_interrupt_flag) else $error("wake without sleep capture");
	chk_flag_read: assert property (rd_stb && addr == `CCTU_ADR_IRQ_FLAGS
		|=> rdata == {7'h00, $past(unit_interrupt_flag)}) else $error("flag read wrong");
	chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
		else $error("read data outside read slot");

	cover property (special_event_trigger && adc_start);
	cover property (wake_request);
	cover property ($rose(unit_pin_oe));
endmodule

bind cctu_unit cctu_unit_chk chk (.mclk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
	.unit_pin_out, .unit_pin_oe, .sleep_active, .adc_start, .special_event_trigger,
	.unit_interrupt_flag, .timer_overflow_flag, .wake_request);

// [tb/capture_compare_timer_unit_bench.sv]
`timescale 1ns/10ps
`include "cctu_map.svh"
module capture_compare_timer_unit_bench;
	import cctu_pkg::*;
	logic       mclk         = 1'b0;
	logic       rst          = 1'b1;
	cctu_addr_t addr         = 3'h0;
	cctu_byte_t wdata        = 8'h00;
	logic       wr_stb       = 1'b0;
	logic       rd_stb       = 1'b0;
	logic       sleep_active = 1'b0;
	logic       adc_enabled  = 1'b0;
	logic       woke         = 1'b0;
	cctu_byte_t rdata;
	cctu_byte_t d;
	logic       pin_out, pin_oe, adc_start, trig, flag, ovf, wake, ext_clk, pin;
	int         n_fail = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	always #2.5 mclk = ~mclk;

	cctu_far_side far (.mclk(mclk), .ext_clk(ext_clk), .pin(pin));
	cctu_unit dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .unit_pin_in(pin), .unit_pin_out(pin_out),
		.unit_pin_oe(pin_oe), .timer_ext_clock_input(ext_clk), .sleep_active(sleep_active),
		.adc_enabled(adc_enabled), .adc_start(adc_start), .special_event_trigger(trig),
		.unit_interrupt_flag(flag), .timer_overflow_flag(ovf), .wake_request(wake));

	always @(posedge mclk) begin
		if (wake === 1'b1) woke <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic test_done;
		$display("checked %0d, unexpected %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input cctu_byte_t exp, input cctu_byte_t got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input cctu_addr_t a, input cctu_byte_t v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input cctu_addr_t a);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rd_chk(input cctu_addr_t a, input cctu_byte_t exp, input string what);
		rd(a);
		chk(what, exp, d);
	endtask

	task automatic wait_on(ref logic s);
		for (int i = 0; i < 300 && s !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
	endtask

	task automatic restart(input logic [3:0] m);
		wr(`CCTU_ADR_TMR_CTRL, 8'h00);
		wr(`CCTU_ADR_TMR_LOW, 8'h00);
		wr(`CCTU_ADR_CONTROL, 8'h00);
		wr(`CCTU_ADR_IRQ_FLAGS, 8'h00);
		wr(`CCTU_ADR_CONTROL, {4'h0, m});
	endtask

	task automatic run_mode(input logic [3:0] m, input cctu_byte_t pin_exp);
		restart(m);
		wr(`CCTU_ADR_TMR_CTRL, 8'h01);
		wait_on(flag);
		chk("flag", 8'h01, {7'h00, flag});
		chk("pin", pin_exp, {6'h00, pin_oe, pin_out});
	endtask

	task automatic prescale(input logic [3:0] m, input int n);
		restart(m);
		far.pulses(1'b1, n - 1);
		chk("early flag", 8'h00, {7'h00, flag});
		far.pulses(1'b1, 1);
		chk("capture flag", 8'h01, {7'h00, flag});
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd_chk(`CCTU_ADR_CONTROL, 8'h00, "control");
		rd_chk(`CCTU_ADR_IRQ_FLAGS, 8'h00, "flags");
		rd_chk(`CCTU_ADR_TMR_CTRL, 8'h00, "timer ctrl");
		$display("done: reset values");

		wr(`CCTU_ADR_CMP_LOW, 8'h10);
		run_mode(`CCTU_MODE_SET, 8'h03);
		run_mode(`CCTU_MODE_CLEAR, 8'h02);
		run_mode(`CCTU_MODE_SWI, 8'h00);
		run_mode(`CCTU_MODE_TOGGLE, 8'h03);
		wr(`CCTU_ADR_CONTROL, 8'h00);
		#1 chk("latch", 8'h00, {7'h00, pin_out});
		$display("done: compare modes");

		adc_enabled <= 1'b1;
		restart(`CCTU_MODE_SPECIAL);
		wr(`CCTU_ADR_TMR_CTRL, 8'h01);
		wait_on(trig);
		chk("adc start", 8'h01, {7'h00, adc_start});
		repeat (20) @(posedge mclk);
		rd_chk(`CCTU_ADR_TMR_HIGH, 8'h00, "timer high");
		rd_chk(`CCTU_ADR_TMR_CTRL, 8'h01, "overflow");
		chk("overflow pin", 8'h00, {7'h00, ovf});
		adc_enabled <= 1'b0;
		restart(`CCTU_MODE_SPECIAL);
		wr(`CCTU_ADR_TMR_CTRL, 8'h01);
		wait_on(trig);
		chk("adc gated", 8'h00, {7'h00, adc_start});
		wr(`CCTU_ADR_CMP_LOW, 8'h40);
		rd_chk(`CCTU_ADR_TMR_LOW, 8'h11, "cancelled reset");
		$display("done: special event");

		restart(`CCTU_MODE_CAP_RISE);
		wr(`CCTU_ADR_TMR_CTRL, 8'h03);
		sleep_active <= 1'b1;
		far.pulses(1'b0, 7);
		far.pulses(1'b1, 1);
		chk("wake", 8'h01, {7'h00, woke});
		rd_chk(`CCTU_ADR_CMP_LOW, 8'h07, "capture");
		far.pulses(1'b0, 3);
		far.pulses(1'b1, 1);
		rd_chk(`CCTU_ADR_CMP_LOW, 8'h0a, "recapture");
		wr(`CCTU_ADR_TMR_CTRL, 8'h01);
		rd_chk(`CCTU_ADR_TMR_LOW, 8'h0a, "held count");
		sleep_active <= 1'b0;
		repeat (40) @(posedge mclk);
		rd(`CCTU_ADR_TMR_LOW);
		chk("awake count", 8'h01, {7'h00, d > 8'h0a});
		chk("resumed", 8'h01, {7'h00, d < 8'h18});
		$display("done: capture in sleep");

		prescale(`CCTU_MODE_CAP_FALL, 1);
		prescale(`CCTU_MODE_CAP_RISE, 1);
		prescale(`CCTU_MODE_CAP_4TH, 4);
		prescale(`CCTU_MODE_CAP_16TH, 16);
		restart(`CCTU_MODE_CAP_4TH);
		far.pulses(1'b1, 2);
		wr(`CCTU_ADR_CONTROL, {4'h0, `CCTU_MODE_CAP_16TH});
		far.pulses(1'b1, 14);
		chk("kept prescale", 8'h01, {7'h00, flag});
		$display("done: prescaler");
		test_done();
	end
endmodule
